/* core/xcd_decoder.sv */
// file: xor command block decoder and executor with avalon register slave
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps

module xcd_decoder (
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic [5:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        dout_valid_i,
    input  wire logic [31:0] dout_data_i,
    output logic             dout_ready_o,
    output logic             din_valid_o,
    output logic      [31:0] din_data_o,
    input  wire logic        din_ready_i,
    output logic             med_rd_req_o,
    output logic      [63:0] med_rd_lba_o,
    input  wire logic        med_rd_valid_i,
    input  wire logic [31:0] med_rd_data_i,
    output logic             med_wr_valid_o,
    output logic      [63:0] med_wr_lba_o,
    output logic      [31:0] med_wr_data_o,
    output logic             med_nocache_o,
    output logic             med_fua_o,
    input  wire logic        med_wr_ready_i,
    output logic             med_sync_req_o,
    input  wire logic        med_sync_done_i,
    output logic             status_valid_o,
    output logic             status_check_o
);

    xcd_pkg::xcd_regs_t s;
    xcd_pkg::xcd_regs_t n;

    function automatic logic [7:0] cdb_byte(input logic [255:0] c, input int idx);
        cdb_byte = c[255 - 8 * idx -: 8];
    endfunction

    function automatic logic [31:0] cdb_be32(input logic [255:0] c, input int idx);
        cdb_be32 = c[255 - 8 * idx -: 32];
    endfunction

    logic        is_var;
    logic        is_xpw;
    logic [7:0]  flags;
    logic [15:0] sa;
    logic [63:0] d_lba;
    logic [31:0] d_len;
    logic        bad;

    // decode of the latched command block
    always_comb begin
        is_var = cdb_byte(s.cdb, xcd_pkg::B32_OPC) == xcd_pkg::OPC_VAR32;
        is_xpw = cdb_byte(s.cdb, xcd_pkg::B32_OPC) == xcd_pkg::OPC_XPW10;
        sa = {cdb_byte(s.cdb, xcd_pkg::B32_SA_HI), cdb_byte(s.cdb, xcd_pkg::B32_SA_LO)};
        if (is_var) begin
            flags = cdb_byte(s.cdb, xcd_pkg::B32_FLAGS);
            d_lba = {cdb_be32(s.cdb, xcd_pkg::B32_LBA),
                     cdb_be32(s.cdb, xcd_pkg::B32_LBA + 4)};
            d_len = cdb_be32(s.cdb, xcd_pkg::B32_LEN);
        end else begin
            flags = cdb_byte(s.cdb, xcd_pkg::B10_FLAGS);
            d_lba = {32'h00000000, cdb_be32(s.cdb, xcd_pkg::B10_LBA)};
            d_len = {16'h0000, cdb_byte(s.cdb, xcd_pkg::B10_LEN),
                     cdb_byte(s.cdb, xcd_pkg::B10_LEN + 1)};
        end
        bad = !(is_var || is_xpw)
            || (is_var && cdb_byte(s.cdb, xcd_pkg::B32_ADDL) != xcd_pkg::ADDL_LEN_XDWR)
            || (is_var && sa != xcd_pkg::SA_XDWRITERD)
            || (is_var && !s.bidir)
            || (d_len > s.maxlen);
    end

    always_comb begin
        n = s;
        n.bus.ack = 1'b0;
        n.med.rd_req = 1'b0;
        n.stat_valid = 1'b0;

        // avalon slave: one wait cycle, then answer
        if ((avs_read_i || avs_write_i) && !s.bus.ack) begin
            n.bus.ack = 1'b1;
            n.bus.rdata = 32'h00000000;
            if (avs_address_i <= xcd_pkg::REG_CDB_LAST) begin
                n.bus.rdata = s.cdb[255 - 8 * avs_address_i -: 32];
            end else if (avs_address_i == xcd_pkg::REG_CTRL) begin
                n.bus.rdata[xcd_pkg::CTRL_GO] = s.go;
                n.bus.rdata[xcd_pkg::CTRL_RCD] = s.rcd;
                n.bus.rdata[xcd_pkg::CTRL_WCE] = s.wce;
                n.bus.rdata[xcd_pkg::CTRL_BIDIR] = s.bidir;
            end else if (avs_address_i == xcd_pkg::REG_MAXLEN) begin
                n.bus.rdata = s.maxlen;
            end else if (avs_address_i == xcd_pkg::REG_STATUS) begin
                n.bus.rdata = {24'h000000, s.st, 1'b0, s.stat_check,
                               s.st != xcd_pkg::XCD_IDLE, s.go};
            end
        end
        n.bus.waitreq = !n.bus.ack;

        // register writes; the command block is frozen while busy
        if (s.bus.ack && avs_write_i) begin
            if (avs_address_i <= xcd_pkg::REG_CDB_LAST && s.st == xcd_pkg::XCD_IDLE && !s.go) begin
                n.cdb[255 - 8 * avs_address_i -: 32] = avs_writedata_i;
            end else if (avs_address_i == xcd_pkg::REG_CTRL) begin
                n.rcd = avs_writedata_i[xcd_pkg::CTRL_RCD];
                n.wce = avs_writedata_i[xcd_pkg::CTRL_WCE];
                n.bidir = avs_writedata_i[xcd_pkg::CTRL_BIDIR];
                if (avs_writedata_i[xcd_pkg::CTRL_GO] && s.st == xcd_pkg::XCD_IDLE) begin
                    n.go = 1'b1;
                end
            end else if (avs_address_i == xcd_pkg::REG_MAXLEN) begin
                n.maxlen = avs_writedata_i;
            end
        end

        case (s.st)
            xcd_pkg::XCD_IDLE: begin
                if (s.go) begin
                    n.go = 1'b0;
                    n.st = xcd_pkg::XCD_DECODE;
                end
            end
            xcd_pkg::XCD_DECODE: begin
                n.xdwr = is_var;
                n.dis_wr = is_var && flags[xcd_pkg::BIT_DISWR];
                n.fua_eff = flags[xcd_pkg::BIT_FUA] && s.wce;
                n.med.nocache = flags[xcd_pkg::BIT_DPO] && !s.rcd;
                n.med.fua = flags[xcd_pkg::BIT_FUA] && s.wce;
                n.lba = d_lba;
                n.left = d_len;
                n.stat_check = bad;
                // rejected blocks move no data at all
                if (bad || d_len == 32'h00000000) begin
                    n.st = xcd_pkg::XCD_STATUS;
                end else begin
                    n.st = xcd_pkg::XCD_RD_REQ;
                end
            end
            xcd_pkg::XCD_RD_REQ: begin
                n.med.rd_req = 1'b1;
                n.med.rd_lba = s.lba;
                n.st = xcd_pkg::XCD_RD_WT;
            end
            xcd_pkg::XCD_RD_WT: begin
                if (med_rd_valid_i) begin
                    n.med_word = med_rd_data_i;
                    n.dout_ready = 1'b1;
                    n.st = xcd_pkg::XCD_DOUT;
                end
            end
            xcd_pkg::XCD_DOUT: begin
                if (dout_valid_i) begin
                    n.dout_ready = 1'b0;
                    n.dout_word = dout_data_i;
                    if (s.xdwr) begin
                        n.din_valid = 1'b1;
                        n.din_data = dout_data_i ^ s.med_word;
                        n.st = xcd_pkg::XCD_DIN;
                    end else begin
                        n.med.wr_valid = 1'b1;
                        n.med.wr_lba = s.lba;
                        n.med.wr_data = dout_data_i ^ s.med_word;
                        n.st = xcd_pkg::XCD_WR;
                    end
                end
            end
            xcd_pkg::XCD_DIN: begin
                if (din_ready_i) begin
                    n.din_valid = 1'b0;
                    // write half stores the incoming data, not the xor
                    if (s.dis_wr) begin
                        n.st = xcd_pkg::XCD_NEXT;
                    end else begin
                        n.med.wr_valid = 1'b1;
                        n.med.wr_lba = s.lba;
                        n.med.wr_data = s.dout_word;
                        n.st = xcd_pkg::XCD_WR;
                    end
                end
            end
            xcd_pkg::XCD_WR: begin
                if (med_wr_ready_i) begin
                    n.med.wr_valid = 1'b0;
                    n.st = xcd_pkg::XCD_NEXT;
                end
            end
            xcd_pkg::XCD_NEXT: begin
                n.lba = s.lba + 64'h1;
                n.left = s.left - 32'h1;
                if (s.left != 32'h1) begin
                    n.st = xcd_pkg::XCD_RD_REQ;
                end else if (s.fua_eff && !s.dis_wr) begin
                    n.med.sync_req = 1'b1;
                    n.st = xcd_pkg::XCD_SYNC;
                end else begin
                    n.st = xcd_pkg::XCD_STATUS;
                end
            end
            xcd_pkg::XCD_SYNC: begin
                // good status waits for the medium to confirm
                if (med_sync_done_i) begin
                    n.med.sync_req = 1'b0;
                    n.st = xcd_pkg::XCD_STATUS;
                end
            end
            xcd_pkg::XCD_STATUS: begin
                n.stat_valid = 1'b1;
                n.st = xcd_pkg::XCD_IDLE;
            end
            default: begin
                n.st = xcd_pkg::XCD_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            s <= '0;
            s.st <= xcd_pkg::XCD_IDLE;
            s.bus.waitreq <= 1'b1;
            s.maxlen <= xcd_pkg::MAXLEN_RST;
            s.rcd <= xcd_pkg::CTRL_RST[xcd_pkg::CTRL_RCD];
        end else begin
            s <= n;
        end
    end

    assign avs_readdata_o    = s.bus.rdata;
    assign avs_waitrequest_o = s.bus.waitreq;
    assign dout_ready_o      = s.dout_ready;
    assign din_valid_o       = s.din_valid;
    assign din_data_o        = s.din_data;
    assign med_rd_req_o      = s.med.rd_req;
    assign med_rd_lba_o      = s.med.rd_lba;
    assign med_wr_valid_o    = s.med.wr_valid;
    assign med_wr_lba_o      = s.med.wr_lba;
    assign med_wr_data_o     = s.med.wr_data;
    assign med_nocache_o     = s.med.nocache;
    assign med_fua_o         = s.med.fua;
    assign med_sync_req_o    = s.med.sync_req;
    assign status_valid_o    = s.stat_valid;
    assign status_check_o    = s.stat_check;

endmodule // xcd_decoder

/* core/xcd_pkg.sv */
// package: constants and types for the xor command block decoder
package xcd_pkg;
    // command block layout
    localparam logic [7:0]  OPC_VAR32     = 8'h7f;
    localparam logic [7:0]  OPC_XPW10     = 8'h51;
    localparam logic [7:0]  ADDL_LEN_XDWR = 8'h18;
    localparam logic [15:0] SA_XDWRITERD  = 16'h0007;
    localparam int          CDB_BYTES     = 32;
    localparam int          B32_OPC       = 0;
    localparam int          B32_ADDL      = 7;
    localparam int          B32_SA_HI     = 8;
    localparam int          B32_SA_LO     = 9;
    localparam int          B32_FLAGS     = 10;
    localparam int          B32_LBA       = 12;
    localparam int          B32_LEN       = 28;
    localparam int          B10_FLAGS     = 1;
    localparam int          B10_LBA       = 2;
    localparam int          B10_LEN       = 7;
    localparam int          BIT_DPO       = 4;
    localparam int          BIT_FUA       = 3;
    localparam int          BIT_DISWR     = 2;

    // register byte offsets
    localparam logic [5:0]  REG_CDB_BASE  = 6'h00;
    localparam logic [5:0]  REG_CDB_LAST  = 6'h1c;
    localparam logic [5:0]  REG_CTRL      = 6'h20;
    localparam logic [5:0]  REG_MAXLEN    = 6'h24;
    localparam logic [5:0]  REG_STATUS    = 6'h28;
    localparam int          CTRL_GO       = 0;
    localparam int          CTRL_RCD      = 1;
    localparam int          CTRL_WCE      = 2;
    localparam int          CTRL_BIDIR    = 3;
    localparam logic [31:0] MAXLEN_RST    = 32'h0000ffff;
    localparam logic [31:0] CTRL_RST      = 32'h00000002;

    typedef enum logic [3:0] {
        XCD_IDLE   = 4'h0,
        XCD_DECODE = 4'h1,
        XCD_RD_REQ = 4'h2,
        XCD_RD_WT  = 4'h3,
        XCD_DOUT   = 4'h4,
        XCD_DIN    = 4'h5,
        XCD_WR     = 4'h6,
        XCD_NEXT   = 4'h7,
        XCD_SYNC   = 4'h8,
        XCD_STATUS = 4'h9
    } xcd_state_t;

    typedef struct packed {
        logic        waitreq;
        logic        ack;
        logic [31:0] rdata;
    } xcd_bus_t;

    typedef struct packed {
        logic        rd_req;
        logic [63:0] rd_lba;
        logic        wr_valid;
        logic [63:0] wr_lba;
        logic [31:0] wr_data;
        logic        nocache;
        logic        fua;
        logic        sync_req;
    } xcd_med_t;

    typedef struct packed {
        xcd_state_t   st;
        xcd_bus_t     bus;
        xcd_med_t     med;
        logic [255:0] cdb;
        logic         rcd;
        logic         wce;
        logic         bidir;
        logic [31:0]  maxlen;
        logic         go;
        logic         xdwr;
        logic         dis_wr;
        logic         fua_eff;
        logic [63:0]  lba;
        logic [31:0]  left;
        logic [31:0]  dout_word;
        logic [31:0]  med_word;
        logic         dout_ready;
        logic         din_valid;
        logic [31:0]  din_data;
        logic         stat_valid;
        logic         stat_check;
    } xcd_regs_t;
endpackage

/* tb/xcd_decoder_asserts.sv */
// checker: port-level properties of the xor command decoder
`timescale 1ns/1ps
module xcd_checker (
    input wire logic        core_clk_i,
    input wire logic        reset_n_i,
    input wire logic        med_rd_req_o,
    input wire logic        dout_ready_o,
    input wire logic        din_valid_o,
    input wire logic        din_ready_i,
    input wire logic [31:0] din_data_o,
    input wire logic        med_wr_valid_o,
    input wire logic        med_wr_ready_i,
    input wire logic [31:0] med_wr_data_o,
    input wire logic        med_sync_req_o,
    input wire logic        med_sync_done_i,
    input wire logic        med_fua_o,
    input wire logic        status_valid_o,
    input wire logic        status_check_o
);
    logic moved;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    // any data phase since the last status; refused commands must show none
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i || status_valid_o) moved <= 1'b0;
        else if (med_rd_req_o || dout_ready_o) moved <= 1'b1;
    end
    AST_RD_PULSE: assert property (med_rd_req_o |=> !med_rd_req_o)
        else $error("medium read request longer than one cycle");
    AST_DIN_HOLD: assert property (din_valid_o && !din_ready_i |=>
        din_valid_o && $stable(din_data_o))
        else $error("xor result dropped before host took it");
    AST_WR_HOLD: assert property (med_wr_valid_o && !med_wr_ready_i |=>
        med_wr_valid_o && $stable(med_wr_data_o))
        else $error("medium write changed before accepted");
    AST_SYNC_HOLD: assert property (med_sync_req_o && !med_sync_done_i |=>
        med_sync_req_o)
        else $error("sync request dropped early");
    AST_SYNC_FUA: assert property (med_sync_req_o |-> med_fua_o && !status_valid_o)
        else $error("status while sync pending or sync without fua");
    AST_REFUSE_NODATA: assert property (status_valid_o && status_check_o |-> !moved)
        else $error("refused command moved data");
    AST_STAT_PULSE: assert property (status_valid_o |=> !status_valid_o)
        else $error("status pulse too long");
    AST_DIN_THEN_WR: assert property (din_valid_o |-> !med_wr_valid_o)
        else $error("medium write overlaps result transfer");
endmodule // xcd_checker

bind xcd_decoder xcd_checker u_chk (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .med_rd_req_o(med_rd_req_o), .dout_ready_o(dout_ready_o), .din_valid_o(din_valid_o),
    .din_ready_i(din_ready_i), .din_data_o(din_data_o), .med_wr_valid_o(med_wr_valid_o),
    .med_wr_ready_i(med_wr_ready_i), .med_wr_data_o(med_wr_data_o),
    .med_sync_req_o(med_sync_req_o), .med_sync_done_i(med_sync_done_i),
    .med_fua_o(med_fua_o), .status_valid_o(status_valid_o), .status_check_o(status_check_o));

/* tb/xcd_host_model.sv */
// host and medium model facing the decoder's data side
`timescale 1ns/1ps
module xcd_host_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        slow_i,
    input  wire logic        rd_req_i,
    input  wire logic [63:0] rd_lba_i,
    input  wire logic        sync_req_i,
    input  wire logic        dout_ready_i,
    input  wire logic        status_i,
    output logic             rd_valid_o,
    output logic      [31:0] rd_data_o,
    output logic             wr_ready_o,
    output logic             sync_done_o,
    output logic             dout_valid_o,
    output logic      [31:0] dout_data_o,
    output logic             din_ready_o
);
    logic [2:0]  dly;
    logic        pend;
    logic        ph;
    logic [31:0] word;
    logic [31:0] nblk;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            {pend, dly, nblk, rd_valid_o, sync_done_o, ph} <= '0;
        end else begin
            ph <= !ph;
            rd_valid_o <= 1'b0;
            if (rd_req_i) begin
                pend <= 1'b1;
                dly <= slow_i ? 3'h4 : 3'h0;
                word <= 32'h0f0f0000 | {16'h0, rd_lba_i[15:0]};
            end else if (pend && dly == 3'h0) begin
                pend <= 1'b0;
                rd_valid_o <= 1'b1;
            end else if (pend) dly <= dly - 3'h1;
            // physical write done; slow mode makes good status wait longer
            sync_done_o <= sync_req_i && !sync_done_o && (ph || !slow_i);
            if (status_i) nblk <= '0;
            else if (dout_ready_i) nblk <= nblk + 32'h1;
        end
    end
    // released read bus shows inverted data so stale values never match
    assign rd_data_o = rd_valid_o ? word : ~word;
    assign wr_ready_o = ph || !slow_i;
    assign din_ready_o = ph || !slow_i;
    assign dout_valid_o = 1'b1;
    assign dout_data_o = 32'ha5a50000 + nblk;
endmodule // xcd_host_model

/* tb/testbench.sv */
// testbench: xor command decoder over avalon with host and medium model
`timescale 1ns/1ps
module testbench;
    logic        clk, rst_n, slow, rd, wr, waitreq, dv, dr, iv, ir, rq, rv, wv, wrdy;
    logic        nc_o, fua, sq, sd, st, sc_o, sv, sc, nc, ss, fu;
    logic [5:0]  addr;
    logic [31:0] wdata, rdata, dd, idat, rdat, wdat;
    logic [63:0] rlba, wlba;
    logic [31:0] wd[$];
    logic [31:0] dq[$];
    logic [63:0] wl[$];
    logic [63:0] rl[$];
    int          mismatches, checked;
    xcd_decoder u_xcd_decoder (.core_clk_i(clk), .reset_n_i(rst_n), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
        .avs_waitrequest_o(waitreq), .dout_valid_i(dv), .dout_data_i(dd), .dout_ready_o(dr),
        .din_valid_o(iv), .din_data_o(idat), .din_ready_i(ir), .med_rd_req_o(rq),
        .med_rd_lba_o(rlba), .med_rd_valid_i(rv), .med_rd_data_i(rdat), .med_wr_valid_o(wv),
        .med_wr_lba_o(wlba), .med_wr_data_o(wdat), .med_nocache_o(nc_o), .med_fua_o(fua),
        .med_wr_ready_i(wrdy), .med_sync_req_o(sq), .med_sync_done_i(sd),
        .status_valid_o(st), .status_check_o(sc_o));
    xcd_host_model u_xcd_host_model (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow),
        .rd_req_i(rq), .rd_lba_i(rlba), .sync_req_i(sq), .dout_ready_i(dr), .status_i(st),
        .rd_valid_o(rv), .rd_data_o(rdat), .wr_ready_o(wrdy), .sync_done_o(sd),
        .dout_valid_o(dv), .dout_data_o(dd), .din_ready_o(ir));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (wv && wrdy) begin
            wl.push_back(wlba);
            wd.push_back(wdat);
            nc = nc_o;
            fu = fua;
        end
        if (rq) rl.push_back(rlba);
        if (iv && ir) dq.push_back(idat);
        if (sq) ss = 1'b1;
        if (st) begin
            sv = 1'b1;
            sc = sc_o;
        end
    end
    task cmp(input string what, input logic [63:0] e, input logic [63:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task final_report;
        $display("counts: %0d checked, %0d mismatches", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task av(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do @(posedge clk); while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    function logic [255:0] c32(input logic [7:0] f, a, input logic [15:0] s,
                               input logic [63:0] l, input logic [31:0] n);
        return {8'h7f, 8'h00, 40'h0, a, s, f, 8'h00, l, 64'h0, n};
    endfunction
    function logic [255:0] c10(input logic [7:0] op, f, input logic [31:0] l,
                               input logic [15:0] n);
        return {op, f, l, 8'h00, n, 8'h00, 176'h0};
    endfunction
    task run(input logic [255:0] c, input logic [31:0] ctrl, input logic e);
        logic [31:0] q;
        for (int i = 0; i < 8; i++) av(1'b1, 6'(4 * i), c[255 - 32 * i -: 32], q);
        wl.delete();
        rl.delete();
        wd.delete();
        dq.delete();
        sv = 1'b0;
        ss = 1'b0;
        av(1'b1, 6'h20, ctrl | 32'h1, q);
        for (int i = 0; i < 3000 && !sv; i++) @(posedge clk);
        cmp("status_seen", 1, sv);
        cmp("status_check", e, sc);
    endtask
    task blocks(input logic [63:0] l, input int n, input logic xd, input logic dw);
        logic [31:0] m, o;
        for (int k = 0; k < n; k++) begin
            m = 32'h0f0f0000 | {16'h0, 16'(l + 64'(k))};
            o = 32'ha5a50000 + 32'(k);
            cmp("rd_lba", l + 64'(k), rl[k]);
            if (xd) cmp("din", m ^ o, dq[k]);
            if (!dw) cmp("wr_lba", l + 64'(k), wl[k]);
            if (!dw) cmp("wr_data", xd ? o : m ^ o, wd[k]);
        end
        cmp("reads", n, rl.size());
        cmp("writes", dw ? 0 : n, wl.size());
        cmp("din_words", xd ? n : 0, dq.size());
    endtask
    task t_regs;
        logic [31:0] q;
        av(1'b0, 6'h20, 32'h0, q);
        cmp("ctrl_rst", 32'h2, q);
        av(1'b0, 6'h24, 32'h0, q);
        cmp("maxlen_rst", 32'hffff, q);
        av(1'b1, 6'h3c, 32'hffffffff, q);
        av(1'b0, 6'h3c, 32'h0, q);
        cmp("unmapped", 32'h0, q);
        $display("test regs done");
    endtask
    task t_reject;
        logic [255:0] cs [5];
        logic [31:0]  q;
        cs = '{c10(8'h53, 0, 5, 1), c32(0, 8'h17, 16'h7, 9, 1), c32(0, 8'h18, 16'h4, 9, 1),
               c32(0, 8'h18, 16'h7, 9, 1), c10(8'h51, 0, 5, 4)};
        av(1'b1, 6'h24, 32'h3, q);
        for (int i = 0; i < 5; i++) begin
            run(cs[i], i == 3 ? 32'h2 : 32'ha, 1'b1);
            cmp("refused_data", 0, wl.size() + dq.size());
        end
        $display("test reject done");
    endtask
    task t_data;
        run(c10(8'h51, 8'h18, 32'h5, 16'h3), 32'h4, 1'b0);
        blocks(64'h5, 3, 1'b0, 1'b0);
        cmp("nocache", 1, nc);
        cmp("sync", 1, ss);
        cmp("fua", 1, fu);
        @(posedge clk);
        slow <= 1'b1;
        run(c32(8'h10, 8'h18, 16'h7, 64'h100000009, 2), 32'ha, 1'b0);
        blocks(64'h100000009, 2, 1'b1, 1'b0);
        cmp("nocache_rcd", 0, nc);
        cmp("no_sync", 0, ss);
        cmp("no_fua", 0, fu);
        @(posedge clk);
        slow <= 1'b0;
        run(c32(8'h04, 8'h18, 16'h7, 64'd20, 2), 32'h8, 1'b0);
        blocks(64'd20, 2, 1'b1, 1'b1);
        $display("test data done");
    endtask
    initial begin
        {rst_n, slow, rd, wr, addr, wdata, sv, ss} = '0;
        mismatches = 0;
        checked = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_reject;
        t_data;
        final_report;
    end
    // tests need a few hundred cycles; far beyond that means a hang
    initial begin
        repeat (50000) @(posedge clk);
        mismatches++;
        final_report;
    end
endmodule // testbench
